// File: asr_cfg.svh
// register map, reset values and timing counts of the pll status block
// ---------------------------------------------------------------
// Contract
// - bit 7: calibration failed flag
// - bit 6: calibration done flag
// - bits 5:0: calibration chosen band
// - live bit 0: loop locked
// - live bit 2: control railed high
// - live bit 1: control railed low
// - event bit 2 sticky on rail high
// - event bit 1 sticky on rail low
// - event bit 0 sticky on lock loss
// - events clear only by writing one
// - 4-bit lock loss tally, saturating
// - tally write loads written value
// - single shot mode holds lock indication
// - detector disable forces lock indication
// - lock debounce none/570/5700/57000 cycles
// ---------------------------------------------------------------
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH

// ---------------------------------------------------------------
// byte offsets
// ---------------------------------------------------------------
`define ASR_OFS_CAL      8'h00
`define ASR_OFS_LIVE     8'h04
`define ASR_OFS_EVENT    8'h08
`define ASR_OFS_TALLY    8'h0C
`define ASR_OFS_CTRL     8'h10
`define ASR_OFS_MASK     8'h14

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ASR_CAL_FAIL_BIT 7
`define ASR_CAL_DONE_BIT 6
`define ASR_CAL_BAND_MSB 5
`define ASR_LOCK_BIT     0
`define ASR_RAIL_LO_BIT  1
`define ASR_RAIL_HI_BIT  2
`define ASR_TALLY_MSB    3
`define ASR_CTRL_DIS_BIT 0
`define ASR_CTRL_ONE_BIT 1
`define ASR_CTRL_DB_LSB  2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ASR_RST_STATUS   8'h00
`define ASR_RST_TALLY    4'h0
`define ASR_RST_MASK     3'h0
`define ASR_RST_CTRL     4'h8
`define ASR_TALLY_MAX    4'hF

// ---------------------------------------------------------------
// debounce lengths in system clock cycles
// ---------------------------------------------------------------
`define ASR_DB_SHORT     570
`define ASR_DB_MID       5700
`define ASR_DB_LONG      57000

// ---------------------------------------------------------------
// bus responses
// ---------------------------------------------------------------
`define ASR_RESP_OKAY    2'h0
`define ASR_RESP_SLVERR  2'h2

`endif

// File: asr_pkg.sv
// types shared by the pll status block
package asr_pkg;

    // ---------------------------------------------------------------
    // debounce length select
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ASR_DB_NONE,
        ASR_DB_SHORT_SEL,
        ASR_DB_MID_SEL,
        ASR_DB_LONG_SEL
    } asr_db_sel_e;

    typedef logic [15:0] asr_db_cnt_t;

endpackage

// File: asr_debounce.sv
// lock indication debouncer with selectable settle length
`timescale 1ns/1ns
`include "asr_cfg.svh"

module asr_debounce
    import asr_pkg::*;
#(
    parameter int SHORT_CNT = `ASR_DB_SHORT,
    parameter int MID_CNT   = `ASR_DB_MID,
    parameter int LONG_CNT  = `ASR_DB_LONG
)
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // control
    input  wire asr_db_sel_e sel,
    // level in and out
    input  wire logic        level_in,
    output logic             level_out
);

    // ---------------------------------------------------------------
    // settle counter
    // ---------------------------------------------------------------
    asr_db_cnt_t cnt_r;
    asr_db_cnt_t limit_w;
    logic        out_r;
    wire         differ_w = level_in != out_r;
    wire         settle_w = (sel == ASR_DB_NONE) || (cnt_r >= limit_w - 16'h0001);

    assign limit_w = (sel == ASR_DB_SHORT_SEL) ? 16'(SHORT_CNT) :
                     (sel == ASR_DB_MID_SEL)   ? 16'(MID_CNT)   :
                     (sel == ASR_DB_LONG_SEL)  ? 16'(LONG_CNT)  : 16'h0001;
    assign level_out = out_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r <= 16'h0000;
            out_r <= 1'b0;
        end
        else if (ce)
        begin
            if (!differ_w || settle_w)
                cnt_r <= 16'h0000;
            else
                cnt_r <= cnt_r + 16'h0001;
            if (differ_w && settle_w)
                out_r <= level_in;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_db_bypass;
        @(posedge aclk) disable iff (!aresetn)
        (ce && sel == ASR_DB_NONE) |=> (out_r == $past(level_in));
    endproperty
    a_db_bypass: assert property (p_db_bypass) else $error("bypass debounce lagged");

    property p_db_hold;
        @(posedge aclk) disable iff (!aresetn)
        (ce && sel == ASR_DB_SHORT_SEL && differ_w && cnt_r == 16'h0000) |=>
            $stable(out_r);
    endproperty
    a_db_hold: assert property (p_db_hold) else $error("debounce passed too early");

endmodule

// File: asr_regs.sv
// pll status, event flags and lock loss tally behind an axi4-lite slave
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`include "asr_cfg.svh"

module asr_regs
    import asr_pkg::*;
#(
    parameter int ADDR_W   = 8,
    parameter int MID_CNT  = `ASR_DB_MID,
    parameter int LONG_CNT = `ASR_DB_LONG
)
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // pll lock detector pins
    input  wire logic              lock_raw,
    input  wire logic              rail_high_raw,
    input  wire logic              rail_low_raw,
    // calibration engine
    input  wire logic              cal_done,
    input  wire logic              cal_fail,
    input  wire logic [5:0]        cal_band,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    // axi4-lite write data
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // axi4-lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    // axi4-lite read data
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // interrupt and lock indication
    output logic                   irq,
    output logic                   lock_out
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    wire  [2:0] pin_w = {rail_high_raw, rail_low_raw, lock_raw};
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic [2:0] flt_r;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    s1_r[gi]  <= 1'b0;
                    s2_r[gi]  <= 1'b0;
                    s3_r[gi]  <= 1'b0;
                    flt_r[gi] <= 1'b0;
                end
                else if (ce)
                begin
                    s1_r[gi] <= pin_w[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi])
                        flt_r[gi] <= s3_r[gi];
                end
            end
        end
    endgenerate

    wire lock_sync_w = flt_r[0];
    wire rail_lo_w   = flt_r[1];
    wire rail_hi_w   = flt_r[2];

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] cal_r;
    logic [2:0] live_r;
    logic [2:0] ev_r;
    logic [3:0] tally_r;
    logic [3:0] ctrl_r;
    logic [2:0] mask_r;
    logic       once_r;
    logic       irq_r;

    wire         det_dis_w   = ctrl_r[`ASR_CTRL_DIS_BIT];
    wire         one_shot_w  = ctrl_r[`ASR_CTRL_ONE_BIT];
    asr_db_sel_e lock_debounce_select;
    assign lock_debounce_select = asr_db_sel_e'(ctrl_r[`ASR_CTRL_DB_LSB +: 2]);
    wire         single_shot_lock_select = one_shot_w;

    // ---------------------------------------------------------------
    // lock indication path
    // ---------------------------------------------------------------
    logic lock_db_w;

    asr_debounce #(
        .SHORT_CNT (`ASR_DB_SHORT),
        .MID_CNT   (MID_CNT),
        .LONG_CNT  (LONG_CNT)
    ) u_debounce (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .sel       (lock_debounce_select),
        .level_in  (lock_sync_w),
        .level_out (lock_db_w)
    );

    wire lock_ind_w  = det_dis_w | lock_db_w | (single_shot_lock_select & once_r);
    wire lock_fall_w = live_r[`ASR_LOCK_BIT] & ~lock_ind_w;
    wire [2:0] ev_set_w = {rail_hi_w, rail_lo_w, lock_fall_w};

    // ---------------------------------------------------------------
    // axi4-lite handshakes
    // ---------------------------------------------------------------
    logic              aw_got_r;
    logic              w_got_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;

    wire aw_hs_w    = awvalid & awready_r;
    wire w_hs_w     = wvalid & wready_r;
    wire b_done_w   = bvalid_r & bready;
    wire wr_go_w    = aw_got_r & w_got_r & ~bvalid_r;
    wire aw_got_nxt = (aw_got_r | aw_hs_w) & ~b_done_w;
    wire w_got_nxt  = (w_got_r | w_hs_w) & ~b_done_w;
    wire ar_hs_w    = arvalid & arready_r;
    wire rvalid_nxt = ar_hs_w | (rvalid_r & ~rready);

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire [7:0] wa_w = {awaddr_r[7:2], 2'b00};
    wire [7:0] ra_w = {araddr[7:2], 2'b00};
    wire       lo_w = wstrb_r[0];
    wire wr_ev_w    = wr_go_w && lo_w && wa_w == `ASR_OFS_EVENT;
    wire wr_tally_w = wr_go_w && lo_w && wa_w == `ASR_OFS_TALLY;
    wire wr_ctrl_w  = wr_go_w && lo_w && wa_w == `ASR_OFS_CTRL;
    wire wr_mask_w  = wr_go_w && lo_w && wa_w == `ASR_OFS_MASK;
    wire wr_hit_w   = wa_w == `ASR_OFS_CAL || wa_w == `ASR_OFS_LIVE ||
                      wa_w == `ASR_OFS_EVENT || wa_w == `ASR_OFS_TALLY ||
                      wa_w == `ASR_OFS_CTRL || wa_w == `ASR_OFS_MASK;
    wire [2:0] ev_clr_w = wr_ev_w ? wdata_r[2:0] : 3'h0;
    wire [2:0] ev_nxt   = (ev_r & ~ev_clr_w) | ev_set_w;
    wire [3:0] tally_nxt = wr_tally_w ? wdata_r[3:0] :
                           (lock_fall_w && tally_r != `ASR_TALLY_MAX) ?
                           tally_r + 4'h1 : tally_r;

    wire rd_hit_w = ra_w == `ASR_OFS_CAL || ra_w == `ASR_OFS_LIVE ||
                    ra_w == `ASR_OFS_EVENT || ra_w == `ASR_OFS_TALLY ||
                    ra_w == `ASR_OFS_CTRL || ra_w == `ASR_OFS_MASK;
    wire [7:0] rd_mux_w =
        (ra_w == `ASR_OFS_CAL)   ? cal_r :
        (ra_w == `ASR_OFS_LIVE)  ? {5'h00, live_r} :
        (ra_w == `ASR_OFS_EVENT) ? {5'h00, ev_r} :
        (ra_w == `ASR_OFS_TALLY) ? {4'h0, tally_r} :
        (ra_w == `ASR_OFS_CTRL)  ? {4'h0, ctrl_r} :
        (ra_w == `ASR_OFS_MASK)  ? {5'h00, mask_r} : 8'h00;

    // ---------------------------------------------------------------
    // bus state
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `ASR_RESP_OKAY;
        end
        else if (ce)
        begin
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            awready_r <= ~aw_got_nxt;
            wready_r  <= ~w_got_nxt;
            if (aw_hs_w)
                awaddr_r <= awaddr;
            if (w_hs_w)
            begin
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (wr_go_w)
            begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit_w ? `ASR_RESP_OKAY : `ASR_RESP_SLVERR;
            end
            else if (b_done_w)
                bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `ASR_RESP_OKAY;
        end
        else if (ce)
        begin
            arready_r <= ~rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            if (ar_hs_w)
            begin
                rdata_r <= {24'h000000, rd_mux_w};
                rresp_r <= rd_hit_w ? `ASR_RESP_OKAY : `ASR_RESP_SLVERR;
            end
        end
    end

    // ---------------------------------------------------------------
    // status, events, tally
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cal_r   <= `ASR_RST_STATUS;
            live_r  <= 3'h0;
            ev_r    <= 3'h0;
            tally_r <= `ASR_RST_TALLY;
            ctrl_r  <= `ASR_RST_CTRL;
            mask_r  <= `ASR_RST_MASK;
            once_r  <= 1'b0;
            irq_r   <= 1'b0;
        end
        else if (ce)
        begin
            cal_r   <= {cal_fail, cal_done, cal_band};
            live_r  <= {rail_hi_w, rail_lo_w, lock_ind_w};
            ev_r    <= ev_nxt;
            tally_r <= tally_nxt;
            once_r  <= single_shot_lock_select & (once_r | lock_db_w);
            irq_r   <= |(ev_nxt & mask_r);
            if (wr_ctrl_w)
                ctrl_r <= wdata_r[3:0];
            if (wr_mask_w)
                mask_r <= wdata_r[2:0];
        end
    end

    assign awready  = awready_r;
    assign wready   = wready_r;
    assign bvalid   = bvalid_r;
    assign bresp    = bresp_r;
    assign arready  = arready_r;
    assign rvalid   = rvalid_r;
    assign rdata    = rdata_r;
    assign rresp    = rresp_r;
    assign irq      = irq_r;
    assign lock_out = live_r[`ASR_LOCK_BIT];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_cal_read;
        ce && ar_hs_w && ra_w == `ASR_OFS_CAL;
    endsequence

    property p_cal_read;
        @(posedge aclk) disable iff (!aresetn)
        s_cal_read |=> (rvalid_r && rdata_r[7:0] == $past(cal_r));
    endproperty
    a_cal_read: assert property (p_cal_read) else $error("cal read mismatch");

    property p_live_rails;
        @(posedge aclk) disable iff (!aresetn)
        ce |=> (live_r[2:1] == {$past(rail_hi_w), $past(rail_lo_w)});
    endproperty
    a_live_rails: assert property (p_live_rails) else $error("rail status stale");

    property p_lock_forced;
        @(posedge aclk) disable iff (!aresetn)
        (ce && det_dis_w) |=> live_r[0];
    endproperty
    a_lock_forced: assert property (p_lock_forced) else $error("disabled lock not forced");

    property p_one_shot;
        @(posedge aclk) disable iff (!aresetn)
        (ce && one_shot_w && once_r && !wr_ctrl_w) |=> live_r[0];
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one shot lock dropped");

    property p_lol_event;
        @(posedge aclk) disable iff (!aresetn)
        (ce && live_r[0] && !lock_ind_w) |=> (ev_r[0] && !live_r[0]);
    endproperty
    a_lol_event: assert property (p_lol_event) else $error("lock loss not flagged");

    property p_rail_event;
        @(posedge aclk) disable iff (!aresetn)
        (ce && (rail_hi_w || rail_lo_w)) |=>
            (ev_r[2] == $past(rail_hi_w) || ev_r[2]) &&
            (ev_r[1] == $past(rail_lo_w) || ev_r[1]);
    endproperty
    a_rail_event: assert property (p_rail_event) else $error("rail event missed");

    property p_ev_sticky;
        @(posedge aclk) disable iff (!aresetn)
        (ce && ev_r[0] && !ev_clr_w[0]) |=> ev_r[0];
    endproperty
    a_ev_sticky: assert property (p_ev_sticky) else $error("event lost without clear");

    property p_tally_inc;
        @(posedge aclk) disable iff (!aresetn)
        (ce && lock_fall_w && !wr_tally_w && tally_r != 4'hF) |=>
            tally_r == $past(tally_r) + 4'h1;
    endproperty
    a_tally_inc: assert property (p_tally_inc) else $error("tally not counted");

    property p_tally_sat;
        @(posedge aclk) disable iff (!aresetn)
        (ce && tally_r == 4'hF && !wr_tally_w) |=> tally_r == 4'hF;
    endproperty
    a_tally_sat: assert property (p_tally_sat) else $error("tally wrapped");

    property p_tally_load;
        @(posedge aclk) disable iff (!aresetn)
        (ce && wr_tally_w) |=> tally_r == $past(wdata_r[3:0]);
    endproperty
    a_tally_load: assert property (p_tally_load) else $error("tally write lost");

endmodule

// File: tb_apll_status_event_regs.sv
// self-checking testbench of the pll status and event register block
`timescale 1ns/1ns
`include "asr_cfg.svh"

module tb_apll_status_event_regs
    import asr_pkg::*;
;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic        aclk;
    logic        aresetn;
    logic        lock_raw;
    logic        rail_high_raw;
    logic        rail_low_raw;
    logic        cal_done;
    logic        cal_fail;
    logic [5:0]  cal_band;
    logic [7:0]  awaddr;
    logic [2:0]  awprot;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic [7:0]  araddr;
    logic [2:0]  arprot;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        irq;
    logic        lock_out;
    logic        ce;
    logic        bready;
    logic        rready;
    int          miscompares;
    int          samples_checked;
    int          exp_tally;
    int          exp_evt;
    logic [31:0] rnd;
    logic [31:0] d;
    logic [1:0]  r;

    asr_regs #(.ADDR_W(8), .MID_CNT(20), .LONG_CNT(40)) dut
    (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .lock_raw(lock_raw), .rail_high_raw(rail_high_raw), .rail_low_raw(rail_low_raw),
        .cal_done(cal_done), .cal_fail(cal_fail), .cal_band(cal_band),
        .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq(irq), .lock_out(lock_out)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        rnd = lfsr_next(rnd);
        awaddr  <= a;
        awprot  <= rnd[2:0];
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 100);
        if (n >= 100) miscompares++;
        rs = bresp;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        araddr  <= a;
        arprot  <= rnd[5:3];
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        if (n >= 100) miscompares++;
        v  = rdata;
        rs = rresp;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] rs;
        axi_wr(a, v, rs);
        chk({30'h0, rs}, {30'h0, `ASR_RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0]  rs;
        axi_rd(a, v, rs);
        chk(v, e);
        chk({30'h0, rs}, {30'h0, `ASR_RESP_OKAY});
    endtask

    // lock indication fall: loss event and saturating tally
    task automatic model_fall();
        exp_evt   = exp_evt | 1;
        exp_tally = (exp_tally < 15) ? exp_tally + 1 : 15;
    endtask

    // ---------------------------------------------------------------
    // clock, reset, watchdog
    // ---------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    initial
    begin
        idle(20000);
        miscompares++;
        tally_and_finish();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        {aresetn, lock_raw, rail_high_raw, rail_low_raw, cal_done, cal_fail} = 6'h00;
        {awvalid, wvalid, arvalid, cal_band, awprot, arprot} = 15'h0000;
        {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0, 4'hF};
        {ce, bready, rready} = 3'b100;
        miscompares = 0;
        samples_checked = 0;
        exp_tally = 0;
        exp_evt = 0;
        rnd = 32'h0330;
        idle(8);
        aresetn <= 1'b1;
        idle(2);
        // reset values and unmapped place
        rd_chk(`ASR_OFS_CAL, 32'h0);
        rd_chk(`ASR_OFS_LIVE, 32'h0);
        rd_chk(`ASR_OFS_EVENT, 32'h0);
        rd_chk(`ASR_OFS_TALLY, 32'h0);
        rd_chk(`ASR_OFS_CTRL, {28'h0, `ASR_RST_CTRL});
        rd_chk(`ASR_OFS_MASK, 32'h0);
        axi_wr(8'h18, 32'hFF, r);
        chk({30'h0, r}, {30'h0, `ASR_RESP_SLVERR});
        axi_rd(8'h18, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, `ASR_RESP_SLVERR});
        wr(`ASR_OFS_CTRL, 32'h0);
        // calibration result with random fields, read-only on write
        repeat (4)
        begin
            rnd = lfsr_next(rnd);
            d = rnd;
            cal_band <= d[5:0];
            cal_fail <= d[7];
            cal_done <= d[6];
            idle(3);
            wr(`ASR_OFS_CAL, ~d);
            rd_chk(`ASR_OFS_CAL, {24'h0, d[7:0]});
        end
        // live lock and rail status, sticky events
        lock_raw <= 1'b1;
        idle(10);
        rd_chk(`ASR_OFS_LIVE, 32'h1);
        chk({31'h0, lock_out}, 32'h1);
        rail_high_raw <= 1'b1;
        idle(10);
        rd_chk(`ASR_OFS_LIVE, 32'h5);
        wr(`ASR_OFS_EVENT, 32'h4);
        rd_chk(`ASR_OFS_EVENT, 32'h4);
        rail_high_raw <= 1'b0;
        rail_low_raw  <= 1'b1;
        idle(10);
        rd_chk(`ASR_OFS_LIVE, 32'h3);
        rail_low_raw <= 1'b0;
        idle(10);
        rd_chk(`ASR_OFS_EVENT, 32'h6);
        wr(`ASR_OFS_EVENT, 32'h0);
        rd_chk(`ASR_OFS_EVENT, 32'h6);
        wr(`ASR_OFS_EVENT, 32'h2);
        rd_chk(`ASR_OFS_EVENT, 32'h4);
        wr(`ASR_OFS_EVENT, 32'h4);
        rd_chk(`ASR_OFS_EVENT, 32'h0);
        // lock losses to saturation, interrupt unmasked
        wr(`ASR_OFS_MASK, 32'h1);
        repeat (17)
        begin
            lock_raw <= 1'b0;
            idle(10);
            model_fall();
            chk({31'h0, irq}, 32'h1);
            lock_raw <= 1'b1;
            idle(10);
            rd_chk(`ASR_OFS_TALLY, exp_tally);
        end
        rd_chk(`ASR_OFS_EVENT, exp_evt);
        wr(`ASR_OFS_EVENT, 32'h1);
        exp_evt = 0;
        idle(2);
        chk({31'h0, irq}, 32'h0);
        rnd = lfsr_next(rnd);
        exp_tally = rnd[3:0];
        wr(`ASR_OFS_TALLY, rnd);
        rd_chk(`ASR_OFS_TALLY, exp_tally);
        exp_tally = 0;
        wr(`ASR_OFS_TALLY, 32'h0);
        rd_chk(`ASR_OFS_TALLY, 32'h0);
        wstrb <= 4'hE;
        wr(`ASR_OFS_TALLY, 32'h5);
        wstrb <= 4'hF;
        rd_chk(`ASR_OFS_TALLY, 32'h0);
        // masked event leaves interrupt low
        wr(`ASR_OFS_MASK, 32'h0);
        lock_raw <= 1'b0;
        idle(10);
        model_fall();
        chk({31'h0, irq}, 32'h0);
        rd_chk(`ASR_OFS_EVENT, exp_evt);
        // clock enable low freezes the lock path
        ce       <= 1'b0;
        lock_raw <= 1'b1;
        idle(10);
        chk({31'h0, lock_out}, 32'h0);
        ce <= 1'b1;
        idle(10);
        chk({31'h0, lock_out}, 32'h1);
        lock_raw <= 1'b0;
        idle(10);
        model_fall();
        // single shot holds, release lets it fall
        wr(`ASR_OFS_CTRL, 32'h2);
        lock_raw <= 1'b1;
        idle(10);
        lock_raw <= 1'b0;
        idle(10);
        chk({31'h0, lock_out}, 32'h1);
        rd_chk(`ASR_OFS_TALLY, exp_tally);
        wr(`ASR_OFS_CTRL, 32'h0);
        idle(10);
        model_fall();
        chk({31'h0, lock_out}, 32'h0);
        // detector disable forces lock
        wr(`ASR_OFS_CTRL, 32'h1);
        idle(10);
        rd_chk(`ASR_OFS_LIVE, 32'h1);
        wr(`ASR_OFS_CTRL, 32'h0);
        idle(10);
        model_fall();
        rd_chk(`ASR_OFS_TALLY, exp_tally);
        // debounce lengths 40 and 570 cycles
        wr(`ASR_OFS_CTRL, 32'hC);
        lock_raw <= 1'b1;
        idle(20);
        chk({31'h0, lock_out}, 32'h0);
        idle(40);
        chk({31'h0, lock_out}, 32'h1);
        wr(`ASR_OFS_CTRL, 32'h4);
        lock_raw <= 1'b0;
        idle(300);
        chk({31'h0, lock_out}, 32'h1);
        idle(300);
        model_fall();
        chk({31'h0, lock_out}, 32'h0);
        rd_chk(`ASR_OFS_EVENT, exp_evt);
        rd_chk(`ASR_OFS_TALLY, exp_tally);
        tally_and_finish();
    end

endmodule
